// File: logic/p4cx_port.sv
// Four-bit multipurpose port: GPIO, address-decoded chip-select strobes, two added interrupts.
// Assumes core SFR writes are single-cycle pulses and the external bus is driven by the core.
`timescale 1ns/10ps
// Behaviour
// - Four-pin port data register at D8H; each pin's mode set independently.
// - Function 00 makes the pin quasi-bidirectional I/O like port 1.
// - In I/O mode pin 2 feeds third interrupt, pin 3 second, when enabled.
// - Function 01 gives a read strobe for matching external read accesses.
// - Function 10 gives a write strobe for matching external write accesses.
// - Function 11 strobes on either read or write to a matching address.
// - Each pin has a 16-bit base address in high and low byte registers.
// - Pin 3 mode comes from bits 7:6 of the second config register at C3H.
// - Pin 3 address range comes from its base address and compare-length field.
// - Added interrupts detect and request like external interrupts 0 and 1.
// - Interrupt control register at C0H is bit-addressable for single-bit set and clear.
// - A set priority bit puts the matching added interrupt at high priority.
// - Third interrupt enabled by control bit 6, second by control bit 2.
// - Edge mode flag set by falling edge, cleared when the interrupt is serviced.
// - Trigger-type bit set means falling edge, cleared means low level.
// - Vectors 33H and 3BH, polled sixth and seventh, third and second lowest overall.
// - Compare length 00/01/10/11 compares bits 15:0, 15:1, 15:2, 15:8.
// - Strobe pin active high when polarity bit set, active low by default.
// - Config A holds pin 1 upper, pin 0 lower; config B pins 3 and 2.
module p4cx_port (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Special function register bus
	input wire p4cx_pkg::p4cx_sfr_req_t sfr_i,
	input wire logic [7:0] sfr_raddr_i,
	output logic [7:0] sfr_rdata_o,
	output logic sfr_hit_o,
	// External bus seen by the strobes
	input wire p4cx_pkg::p4cx_ext_bus_t bus_i,
	// Port pins
	input wire logic [3:0] pin_i,
	output logic [3:0] pin_o,
	output logic [3:0] pin_oe_o,
	// Interrupt requests toward the core, index 0 is the second, 1 the third
	input wire logic [1:0] irq_ack_i,
	output logic [1:0] irq_req_o,
	output logic [1:0] irq_high_o,
	output logic [7:0] irq_vec_o
);
	import p4cx_pkg::*;

	// ==========================================================
	// Functions
	function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] idx,
			input logic val);
		logic [7:0] r;
		r = old;
		r[idx] = val;
		return r;
	endfunction

	function automatic logic bit_hit(input logic [7:0] bit_addr, input logic [7:0] base);
		return bit_addr[7:3] == base[7:3];
	endfunction

	// ==========================================================
	// Registers
	logic [7:0] base_low [4];
	logic [7:0] base_high [4];
	logic [7:0] cfg_a;
	logic [7:0] cfg_b;
	logic [3:0] polarity;
	logic [3:0] port_data;
	logic prio3;
	logic en3;
	logic edge3;
	logic prio2;
	logic en2;
	logic edge2;
	logic flag2;
	logic flag3;

	logic [7:0] low_addr [4];
	logic [7:0] high_addr [4];
	logic [3:0] func [4];
	logic [7:0] xint_now;
	logic xint_byte_wr;
	logic xint_bit_wr;
	logic port_byte_wr;
	logic port_bit_wr;
	logic [7:0] next_xint;
	logic [7:0] next_port;
	logic [3:0] strobe_level;
	logic [3:0] gpio_mode;

	assign low_addr[0] = P4CX_ADDR_PIN0_LOW;
	assign low_addr[1] = P4CX_ADDR_PIN1_LOW;
	assign low_addr[2] = P4CX_ADDR_PIN2_LOW;
	assign low_addr[3] = P4CX_ADDR_PIN3_LOW;
	assign high_addr[0] = P4CX_ADDR_PIN0_HIGH;
	assign high_addr[1] = P4CX_ADDR_PIN1_HIGH;
	assign high_addr[2] = P4CX_ADDR_PIN2_HIGH;
	assign high_addr[3] = P4CX_ADDR_PIN3_HIGH;

	// Per-pin nibble: function in upper two bits, compare length in lower two
	assign func[0] = cfg_a[3:0];
	assign func[1] = cfg_a[7:4];
	assign func[2] = cfg_b[3:0];
	assign func[3] = cfg_b[7:4];

	// ==========================================================
	// Base address registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++) begin
				base_low[i] <= P4CX_RST_BYTE;
				base_high[i] <= P4CX_RST_BYTE;
			end
		end else if (sfr_i.wr) begin
			for (int i = 0; i < 4; i++) begin
				if (sfr_i.addr == low_addr[i]) begin
					base_low[i] <= sfr_i.wdata;
				end
				if (sfr_i.addr == high_addr[i]) begin
					base_high[i] <= sfr_i.wdata;
				end
			end
		end
	end

	// ==========================================================
	// Mode configuration and polarity
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_a <= P4CX_RST_BYTE;
			cfg_b <= P4CX_RST_BYTE;
			polarity <= P4CX_RST_BYTE[3:0];
		end else if (sfr_i.wr) begin
			if (sfr_i.addr == P4CX_ADDR_CFG_A) begin
				cfg_a <= sfr_i.wdata;
			end
			if (sfr_i.addr == P4CX_ADDR_CFG_B) begin
				cfg_b <= sfr_i.wdata;
			end
			if (sfr_i.addr == P4CX_ADDR_POLARITY) begin
				polarity <= sfr_i.wdata[P4CX_POL_LSB +: 4];
			end
		end
	end

	// ==========================================================
	// Port data latch, byte and bit writable
	assign port_byte_wr = sfr_i.wr && sfr_i.addr == P4CX_ADDR_PORT_DATA;
	assign port_bit_wr = sfr_i.bit_wr && bit_hit(sfr_i.bit_addr, P4CX_ADDR_PORT_DATA);
	assign next_port = port_byte_wr ? sfr_i.wdata :
		bit_merge({4'h0, port_data}, sfr_i.bit_addr[2:0], sfr_i.bit_val);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_data <= P4CX_RST_PORT_DATA;
		end else if (port_byte_wr || port_bit_wr) begin
			port_data <= next_port[3:0];
		end
	end

	// ==========================================================
	// Interrupt control register, byte and bit writable
	assign xint_now = {prio3, en3, flag3, edge3, prio2, en2, flag2, edge2};
	assign xint_byte_wr = sfr_i.wr && sfr_i.addr == P4CX_ADDR_XINT_CTRL;
	assign xint_bit_wr = sfr_i.bit_wr && bit_hit(sfr_i.bit_addr, P4CX_ADDR_XINT_CTRL);
	assign next_xint = xint_byte_wr ? sfr_i.wdata :
		bit_merge(xint_now, sfr_i.bit_addr[2:0], sfr_i.bit_val);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			prio3 <= 1'b0;
			en3 <= 1'b0;
			edge3 <= 1'b0;
			prio2 <= 1'b0;
			en2 <= 1'b0;
			edge2 <= 1'b0;
		end else if (xint_byte_wr || xint_bit_wr) begin
			prio3 <= next_xint[P4CX_XI_PRIO3];
			en3 <= next_xint[P4CX_XI_EN3];
			edge3 <= next_xint[P4CX_XI_EDGE3];
			prio2 <= next_xint[P4CX_XI_PRIO2];
			en2 <= next_xint[P4CX_XI_EN2];
			edge2 <= next_xint[P4CX_XI_EDGE2];
		end
	end

	// ==========================================================
	// Added interrupts
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			gpio_mode[i] = func[i][P4CX_CFG_FUNC_HI:P4CX_CFG_FUNC_LO] == P4CX_FN_GPIO;
		end
	end

	p4cx_xint u_irq2 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pin_i[3]),
		.route_i(gpio_mode[3] && en2),
		.edge_sel_i(edge2),
		.ack_i(irq_ack_i[0]),
		.sw_wr_i(xint_byte_wr || xint_bit_wr),
		.sw_val_i(next_xint[P4CX_XI_FLAG2]),
		.flag_o(flag2)
	);

	p4cx_xint u_irq3 (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i(pin_i[2]),
		.route_i(gpio_mode[2] && en3),
		.edge_sel_i(edge3),
		.ack_i(irq_ack_i[1]),
		.sw_wr_i(xint_byte_wr || xint_bit_wr),
		.sw_val_i(next_xint[P4CX_XI_FLAG3]),
		.flag_o(flag3)
	);

	assign irq_req_o = {flag3 && en3, flag2 && en2};
	assign irq_high_o = {prio3, prio2};

	// Within a level the second is polled ahead of the third
	always_comb begin
		if (irq_req_o[0] && (prio2 || !irq_req_o[1] || !prio3)) begin
			irq_vec_o = P4CX_VEC_IRQ2;
		end else if (irq_req_o[1]) begin
			irq_vec_o = P4CX_VEC_IRQ3;
		end else begin
			irq_vec_o = P4CX_VEC_NONE;
		end
	end

	// ==========================================================
	// Strobe decoders and pin drivers
	for (genvar g = 0; g < 4; g++) begin : g_pin
		p4cx_strobe u_strobe (
			.func_i(p4cx_func_t'(func[g][P4CX_CFG_FUNC_HI:P4CX_CFG_FUNC_LO])),
			.cmp_i(p4cx_cmp_t'(func[g][P4CX_CFG_LEN_HI:P4CX_CFG_LEN_LO])),
			.base_i({base_high[g], base_low[g]}),
			.invert_i(polarity[g]),
			.bus_i(bus_i),
			.level_o(strobe_level[g])
		);

		// Quasi-bidirectional: only a low is driven, a high is the pull-up
		assign pin_o[g] = gpio_mode[g] ? 1'b0 : strobe_level[g];
		assign pin_oe_o[g] = gpio_mode[g] ? !port_data[g] : 1'b1;
	end

	// ==========================================================
	// Register read-back
	always_comb begin
		sfr_hit_o = 1'b1;
		case (sfr_raddr_i)
			P4CX_ADDR_PIN0_LOW: sfr_rdata_o = base_low[0];
			P4CX_ADDR_PIN0_HIGH: sfr_rdata_o = base_high[0];
			P4CX_ADDR_PIN1_LOW: sfr_rdata_o = base_low[1];
			P4CX_ADDR_PIN1_HIGH: sfr_rdata_o = base_high[1];
			P4CX_ADDR_PIN2_LOW: sfr_rdata_o = base_low[2];
			P4CX_ADDR_PIN2_HIGH: sfr_rdata_o = base_high[2];
			P4CX_ADDR_PIN3_LOW: sfr_rdata_o = base_low[3];
			P4CX_ADDR_PIN3_HIGH: sfr_rdata_o = base_high[3];
			P4CX_ADDR_POLARITY: sfr_rdata_o = {polarity, 4'h0} & P4CX_POL_RMASK;
			P4CX_ADDR_XINT_CTRL: sfr_rdata_o = xint_now;
			P4CX_ADDR_CFG_A: sfr_rdata_o = cfg_a;
			P4CX_ADDR_CFG_B: sfr_rdata_o = cfg_b;
			P4CX_ADDR_PORT_DATA: sfr_rdata_o = {4'h0, pin_i};
			default: begin
				sfr_rdata_o = 8'h00;
				sfr_hit_o = 1'b0;
			end
		endcase
	end

endmodule

// File: logic/p4cx_pkg.sv
// Package for the four-bit multipurpose port with chip-select strobes and two added interrupts.
// Assumes one core clock and an 8-bit special function register bus from the core.
package p4cx_pkg;

	// ==========================================================
	// Special function register addresses
	localparam logic [7:0] P4CX_ADDR_PIN0_LOW = 8'h84;
	localparam logic [7:0] P4CX_ADDR_PIN0_HIGH = 8'h85;
	localparam logic [7:0] P4CX_ADDR_PIN1_LOW = 8'h94;
	localparam logic [7:0] P4CX_ADDR_PIN1_HIGH = 8'h95;
	localparam logic [7:0] P4CX_ADDR_PIN2_LOW = 8'hac;
	localparam logic [7:0] P4CX_ADDR_PIN2_HIGH = 8'had;
	localparam logic [7:0] P4CX_ADDR_POLARITY = 8'hae;
	localparam logic [7:0] P4CX_ADDR_PIN3_LOW = 8'hb4;
	localparam logic [7:0] P4CX_ADDR_PIN3_HIGH = 8'hb5;
	localparam logic [7:0] P4CX_ADDR_XINT_CTRL = 8'hc0;
	localparam logic [7:0] P4CX_ADDR_CFG_A = 8'hc2;
	localparam logic [7:0] P4CX_ADDR_CFG_B = 8'hc3;
	localparam logic [7:0] P4CX_ADDR_PORT_DATA = 8'hd8;

	// ==========================================================
	// Reset values
	localparam logic [7:0] P4CX_RST_BYTE = 8'h00;
	localparam logic [3:0] P4CX_RST_PORT_DATA = 4'hf;

	// ==========================================================
	// Field positions
	localparam int P4CX_CFG_FUNC_HI = 3;
	localparam int P4CX_CFG_FUNC_LO = 2;
	localparam int P4CX_CFG_LEN_HI = 1;
	localparam int P4CX_CFG_LEN_LO = 0;
	localparam int P4CX_POL_LSB = 4;
	localparam logic [7:0] P4CX_POL_RMASK = 8'hf0;
	localparam int P4CX_XI_PRIO3 = 7;
	localparam int P4CX_XI_EN3 = 6;
	localparam int P4CX_XI_FLAG3 = 5;
	localparam int P4CX_XI_EDGE3 = 4;
	localparam int P4CX_XI_PRIO2 = 3;
	localparam int P4CX_XI_EN2 = 2;
	localparam int P4CX_XI_FLAG2 = 1;
	localparam int P4CX_XI_EDGE2 = 0;

	// ==========================================================
	// Interrupt vectors, polled sixth and seventh of eight
	localparam logic [7:0] P4CX_VEC_IRQ2 = 8'h33;
	localparam logic [7:0] P4CX_VEC_IRQ3 = 8'h3b;
	localparam logic [7:0] P4CX_VEC_NONE = 8'h00;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		P4CX_FN_GPIO,
		P4CX_FN_READ,
		P4CX_FN_WRITE,
		P4CX_FN_RDWR
	} p4cx_func_t;

	typedef enum logic [1:0] {
		P4CX_CMP_16,
		P4CX_CMP_15,
		P4CX_CMP_14,
		P4CX_CMP_8
	} p4cx_cmp_t;

	typedef struct packed {
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
		logic bit_wr;
		logic [7:0] bit_addr;
		logic bit_val;
	} p4cx_sfr_req_t;

	typedef struct packed {
		logic [15:0] addr;
		logic rd_n;
		logic wr_n;
	} p4cx_ext_bus_t;

endpackage

// File: logic/p4cx_strobe.sv
// One chip-select strobe decoder for a single port pin.
// Assumes the external address is stable while the core read or write strobe is low.
`timescale 1ns/10ps
module p4cx_strobe (
	// Configuration
	input wire p4cx_pkg::p4cx_func_t func_i,
	input wire p4cx_pkg::p4cx_cmp_t cmp_i,
	input wire logic [15:0] base_i,
	input wire logic invert_i,
	// External bus
	input wire p4cx_pkg::p4cx_ext_bus_t bus_i,
	// Pin level in strobe modes
	output logic level_o
);
	import p4cx_pkg::*;

	logic [15:0] mask;
	logic hit;
	logic active;

	// ==========================================================
	// Address compare
	always_comb begin
		case (cmp_i)
			P4CX_CMP_16: mask = 16'hffff;
			P4CX_CMP_15: mask = 16'hfffe;
			P4CX_CMP_14: mask = 16'hfffc;
			P4CX_CMP_8: mask = 16'hff00;
			default: mask = 16'hffff;
		endcase
	end

	assign hit = ((bus_i.addr ^ base_i) & mask) == 16'h0000;

	// ==========================================================
	// Strobe select
	always_comb begin
		case (func_i)
			P4CX_FN_READ: active = hit && !bus_i.rd_n;
			P4CX_FN_WRITE: active = hit && !bus_i.wr_n;
			P4CX_FN_RDWR: active = hit && (!bus_i.rd_n || !bus_i.wr_n);
			default: active = 1'b0;
		endcase
	end

	// Idle level is the inverse of the active one
	assign level_o = invert_i ? active : !active;

endmodule

// File: logic/p4cx_xint.sv
// One added external interrupt: low-level or falling-edge detection and its flag.
// Assumes the pin is synchronous to the clock and the core pulses ack when it vectors here.
`timescale 1ns/10ps
module p4cx_xint (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pin and control
	input wire logic pin_i,
	input wire logic route_i,
	input wire logic edge_sel_i,
	input wire logic ack_i,
	// Software write of the flag
	input wire logic sw_wr_i,
	input wire logic sw_val_i,
	// Flag
	output logic flag_o
);
	import p4cx_pkg::*;

	logic pin_prev;
	logic fall;
	logic src;

	// Unrouted pin looks idle high
	assign src = route_i ? pin_i : 1'b1;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin_prev <= 1'b1;
		end else begin
			pin_prev <= src;
		end
	end

	assign fall = pin_prev && !src;

	// ==========================================================
	// Flag: in edge mode an edge sets it, service clears it, a new edge wins over the clear; in level mode it is set while the routed pin is low
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			flag_o <= 1'b0;
		end else if (edge_sel_i) begin
			if (fall) begin
				flag_o <= 1'b1;
			end else if (ack_i) begin
				flag_o <= 1'b0;
			end else if (sw_wr_i) begin
				flag_o <= sw_val_i;
			end
		end else begin
			flag_o <= !src;
		end
	end

endmodule

// File: verif/p4cx_props.sv
// Checker for the port: vectors, flag clearing, strobe idle, register map.
// Assumes it is bound to the port top module.
`timescale 1ns/10ps
module p4cx_props (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Observed ports
	input wire p4cx_pkg::p4cx_sfr_req_t sfr_i,
	input wire logic [7:0] sfr_raddr_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic sfr_hit_o,
	input wire p4cx_pkg::p4cx_ext_bus_t bus_i,
	input wire logic [3:0] pin_i,
	input wire logic [3:0] pin_o,
	input wire logic [3:0] pin_oe_o,
	input wire logic [1:0] irq_ack_i,
	input wire logic [1:0] irq_req_o,
	input wire logic [1:0] irq_high_o,
	input wire logic [7:0] irq_vec_o
);
	import p4cx_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ========
	// Assertions
	a_vec_none: assert property (irq_req_o == 2'h0 |-> irq_vec_o == 8'h00)
		else $error("vector without request");
	a_vec_second: assert property (irq_req_o[0]
		&& !(irq_req_o[1] && irq_high_o[1] && !irq_high_o[0]) |-> irq_vec_o == 8'h33)
		else $error("second vector wrong");
	a_vec_third: assert property (irq_req_o[1]
		&& (!irq_req_o[0] || (irq_high_o[1] && !irq_high_o[0])) |-> irq_vec_o == 8'h3b)
		else $error("third vector wrong");
	a_ack_clears: assert property (irq_ack_i[0] && pin_i[3]
		&& !sfr_i.wr && !sfr_i.bit_wr |=> !irq_req_o[0])
		else $error("request kept after service");
	a_strobe_quiet: assert property (bus_i.rd_n && bus_i.wr_n
		&& $past(bus_i.rd_n && bus_i.wr_n) && !$past(sfr_i.wr || sfr_i.bit_wr)
		|-> $stable(pin_o) && $stable(pin_oe_o))
		else $error("pin moved without access");
	a_reset_pins: assert property (disable iff (1'b0) rst_i
		|-> pin_oe_o == 4'h0 && irq_req_o == 2'h0)
		else $error("pins driven in reset");
	a_map_data: assert property (sfr_raddr_i == 8'hd8
		|-> sfr_hit_o && sfr_rdata_o == {4'h0, pin_i})
		else $error("port data read wrong");
	a_map_miss: assert property (sfr_raddr_i == 8'h00
		|-> !sfr_hit_o && sfr_rdata_o == 8'h00)
		else $error("unmapped read answered");
	a_req_cause: assert property ($rose(irq_req_o[0])
		|-> !$past(pin_i[3]) || $past(sfr_i.wr || sfr_i.bit_wr))
		else $error("request without low pin");
endmodule

bind p4cx_port p4cx_props i_p4cx_props (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i),
	.sfr_raddr_i(sfr_raddr_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
	.bus_i(bus_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
	.irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_high_o(irq_high_o),
	.irq_vec_o(irq_vec_o));

// File: verif/p4cx_periph.sv
// Far side of the port: pull-ups and interrupt sources pulling pins low.
// Assumes the bench commands the sources and never pulls a strobe pin.
`timescale 1ns/10ps
module p4cx_periph (
	// Port drive
	input wire logic [3:0] pin_o,
	input wire logic [3:0] pin_oe_o,
	// Source commands
	input wire logic [3:0] pull_low_i,
	// Resolved pin level
	output logic [3:0] wire_o
);
	// Strobe pins are only observed as select, never driven from here
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			wire_o[i] = pin_oe_o[i] ? pin_o[i] : !pull_low_i[i];
		end
	end
endmodule

// File: verif/p4cx_port_bench.sv
// Bench for the port: register map, strobe decoding, GPIO, added interrupts.
// Assumes the checker binds itself and the partner resolves the pins.
`timescale 1ns/10ps
module p4cx_port_bench;
	import p4cx_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b0;
	p4cx_sfr_req_t sfr_i = '0;
	logic [7:0] sfr_raddr_i = 8'h00;
	logic [7:0] sfr_rdata_o, eb, vec;
	logic sfr_hit_o, pol;
	p4cx_ext_bus_t bus_i = {16'h0000, 2'b11};
	p4cx_ext_bus_t x;
	logic [3:0] pin_i, pin_o, pin_oe_o, cfg, pn;
	logic [3:0] pull_low = 4'h0;
	logic [1:0] irq_ack_i = 2'h0;
	logic [1:0] irq_req_o, irq_high_o;
	logic [7:0] irq_vec_o;
	logic [31:0] seed = 32'd90173;
	logic [31:0] r;
	logic [15:0] base;
	logic [7:0] lo [4] = '{8'h84, 8'h94, 8'hac, 8'hb4};
	int err_total = 0;
	int comparisons = 0;

	p4cx_port i_p4cx_port (.clk_i(clk_i), .rst_i(rst_i), .sfr_i(sfr_i),
		.sfr_raddr_i(sfr_raddr_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
		.bus_i(bus_i), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
		.irq_ack_i(irq_ack_i), .irq_req_o(irq_req_o), .irq_high_o(irq_high_o),
		.irq_vec_o(irq_vec_o));
	p4cx_periph i_p4cx_periph (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_low_i(pull_low),
		.wire_o(pin_i));

	initial begin
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_total++;
		close_out();
	end

	// ========
	// Expectations
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [15:0] msk(input logic [1:0] l);
		case (l)
			2'h0: return 16'hffff;
			2'h1: return 16'hfffe;
			2'h2: return 16'hfffc;
			default: return 16'hff00;
		endcase
	endfunction
	function automatic logic lvl(input logic [3:0] c, input logic [15:0] b, input logic p,
		input p4cx_ext_bus_t e);
		logic act;
		act = (((e.addr ^ b) & msk(c[1:0])) == 16'h0000)
			&& ((c[2] && !e.rd_n) || (c[3] && !e.wr_n));
		return p ? act : !act;
	endfunction

	// ========
	// Bus cycles and compares
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		sfr_i <= '{wr: 1'b1, addr: a, wdata: d, default: '0};
		@(posedge clk_i);
		sfr_i <= '0;
	endtask
	task automatic wr_bit(input logic [7:0] a, input logic v);
		@(posedge clk_i);
		sfr_i <= '{bit_wr: 1'b1, bit_addr: a, bit_val: v, default: '0};
		@(posedge clk_i);
		sfr_i <= '0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_i);
		sfr_raddr_i <= a;
		@(negedge clk_i);
		chk(sfr_rdata_o, exp, "register");
	endtask
	task automatic settle(input logic [3:0] pl);
		@(posedge clk_i);
		pull_low <= pl;
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
	endtask
	task automatic chk_irq(input logic [1:0] req, input logic [7:0] v);
		chk({6'h0, irq_req_o}, {6'h0, req}, "request");
		chk(irq_vec_o, v, "vector");
	endtask
	task automatic ack(input logic [1:0] k);
		@(posedge clk_i);
		irq_ack_i <= k;
		@(posedge clk_i);
		irq_ack_i <= 2'h0;
		@(negedge clk_i);
	endtask
	task automatic close_out();
		if (err_total == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ========
	// Main sequence
	initial begin
		// A real rising edge on reset, so the asynchronous branches clear at once
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		foreach (lo[i]) begin
			rd_chk(lo[i], 8'h00);
			rd_chk(lo[i] + 8'h01, 8'h00);
		end
		rd_chk(8'hc0, 8'h00);
		rd_chk(8'hc2, 8'h00);
		rd_chk(8'hd8, 8'h0f);
		rd_chk(8'h00, 8'h00);
		chk({7'h0, sfr_hit_o}, 8'h00, "hit");
		wr_reg(8'hae, 8'hff);
		rd_chk(8'hae, 8'hf0);
		for (int p = 0; p < 4; p++) begin
			for (int f = 1; f < 4; f++) begin
				for (int l = 0; l < 4; l++) begin
					r = rnd();
					base = r[15:0];
					pol = r[20];
					cfg = {f[1:0], l[1:0]};
					wr_reg(lo[p], base[7:0]);
					wr_reg(lo[p] + 8'h01, base[15:8]);
					wr_reg(8'hae, 8'(pol) << (4 + p));
					wr_reg(p < 2 ? 8'hc2 : 8'hc3, 8'(cfg) << (4 * (p % 2)));
					repeat (3) begin
						r = rnd();
						x = {r[16] ? base ^ (r[15:0] & ~msk(cfg[1:0])) : r[15:0], r[17], r[18]};
						@(posedge clk_i);
						bus_i <= x;
						@(negedge clk_i);
						chk({7'h0, pin_o[p]}, {7'h0, lvl(cfg, base, pol, x)}, "strobe");
						chk({7'h0, pin_oe_o[p]}, 8'h01, "enable");
						@(posedge clk_i);
						bus_i <= {x.addr, 2'b11};
						@(negedge clk_i);
						chk({7'h0, pin_o[p]}, {7'h0, !pol}, "idle");
					end
				end
			end
		end
		rd_chk(8'hc3, 8'hf0);
		wr_reg(8'hc2, 8'h00);
		wr_reg(8'hc3, 8'h00);
		wr_reg(8'hd8, 8'h05);
		@(negedge clk_i);
		chk({4'h0, pin_oe_o}, 8'h0a, "gpio enable");
		rd_chk(8'hd8, 8'h05);
		wr_reg(8'hd8, 8'h0f);
		for (int k = 0; k < 2; k++) begin
			pn = k ? 4'h4 : 4'h8;
			eb = k ? 8'hc6 : 8'hc2;
			vec = k ? 8'h3b : 8'h33;
			wr_reg(8'hc0, 8'h00);
			wr_bit(eb, 1'b1);
			wr_bit(eb - 8'h02, 1'b1);
			settle(pn);
			chk_irq(2'(1 << k), vec);
			settle(4'h0);
			chk_irq(2'(1 << k), vec);
			rd_chk(8'hc0, k ? 8'h70 : 8'h07);
			ack(2'(1 << k));
			chk_irq(2'h0, 8'h00);
			wr_bit(eb - 8'h02, 1'b0);
			settle(pn);
			chk_irq(2'(1 << k), vec);
			settle(4'h0);
			chk_irq(2'h0, 8'h00);
			wr_bit(eb, 1'b0);
			settle(pn);
			chk_irq(2'h0, 8'h00);
			settle(4'h0);
			wr_bit(eb + 8'h01, 1'b1);
			@(negedge clk_i);
			chk({6'h0, irq_high_o}, {6'h0, 2'(1 << k)}, "priority");
		end
		wr_reg(8'hc0, 8'h55);
		settle(4'hc);
		settle(4'h0);
		chk_irq(2'h3, 8'h33);
		wr_bit(8'hc7, 1'b1);
		@(negedge clk_i);
		chk_irq(2'h3, 8'h3b);
		ack(2'h3);
		chk_irq(2'h0, 8'h00);
		close_out();
	end
endmodule
